/* rtl/sbsc_pkg.sv */
// constants of the synchronous burst sram cycle controller
// assumes one clock domain, core_clk at 200 mhz, apb register access
package sbsc_pkg;
    localparam int ADDR_W      = 17;
    localparam int LANE_W      = 9;
    localparam int LANES       = 4;
    localparam int DATA_W      = LANE_W * LANES;
    localparam int UPPER_W     = ADDR_W - 2;
    localparam int TRACE_W     = ADDR_W + 1;
    localparam int FIFO_DEPTH  = 8;
    localparam int DROP_W      = 8;
    // apb register byte addresses
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_TRACE  = 12'h008;
    // ctrl fields and reset values
    localparam int          CTRL_TRACE_EN_BIT = 0;
    localparam logic        CTRL_TRACE_EN_RST = 1'b0;
    // status fields
    localparam int STAT_ACTIVE_BIT  = 0;
    localparam int STAT_POS_LSB     = 1;
    localparam int STAT_LINEAR_BIT  = 3;
    localparam int STAT_READY_BIT   = 4;
    localparam int STAT_PEND_BIT    = 5;
    localparam int STAT_TAPRST_BIT  = 6;
    localparam int STAT_DROP_LSB    = 16;
    // trace word fields
    localparam int TRACE_VALID_BIT  = 31;
    localparam int TRACE_WRITE_BIT  = ADDR_W;
endpackage

/* rtl/sbsc_top.sv */
// burst sram cycle decode, burst counter, storage array, trace fifo, apb
// assumes every input synchronous to core_clk; output enable is sampled
//
// Behaviour
// RULE1 - high order select gives interleaved xor burst
// RULE2 - grounded order select gives linear modulo-four burst
// RULE3 - enabled processor strobe starts read, ignoring writes
// RULE4 - controller writes in the wait cycle after processor start
// RULE5 - controller strobe starts write or read burst
// RULE6 - disabled start deselects, powers down, floats data (no power-down state here: it ends the burst and floats data)
// RULE7 - step low continues read, driven only with oe
// RULE8 - step low with write writes next address
// RULE9 - step high repeats read at current address
// RULE10 - step high with write writes current address
// RULE11 - suspended burst is a wait, position held
// RULE12 - global write all bytes, else lane decode
// RULE13 - each lane strobe writes only its lane
// RULE14 - controller raises oe early before write after read
// RULE15 - data outputs float from power-up until access
// RULE16 - unused scan: test clock low, output open
// RULE17 - test logic self-resets, never disturbs memory
// RULE18 - primary enable high blocks processor strobe
// RULE19 - burst counter alters only two low bits
`timescale 1ns/1ps

module sbsc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    // pointer step with wrap at depth, shared by both pointers
    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } sbsc_fifo_s;

    sbsc_fifo_s st_r;
    sbsc_fifo_s st_nxt;
    logic       push;
    logic       pop;

    assign in_ready  = (st_r.cnt != (PW+1)'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        st_nxt = st_r;

        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = wrap_inc(st_r.wp);
        end
        if (pop) begin
            st_nxt.rp = wrap_inc(st_r.rp);
        end

        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // sbsc_fifo

module sbsc_top
    import sbsc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // sram side
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              chip_enable_n,
    input  wire logic              depth_select,
    input  wire logic              depth_select_n,
    input  wire logic              addr_strobe_proc,
    input  wire logic              addr_strobe_ctrl,
    input  wire logic              burst_step_n,
    input  wire logic              global_write_n,
    input  wire logic              byte_write_gate_n,
    input  wire logic              lane_a_write_n,
    input  wire logic              lane_b_write_n,
    input  wire logic              lane_c_write_n,
    input  wire logic              lane_d_write_n,
    input  wire logic              out_enable_n,
    input  wire logic              burst_order_sel,
    input  wire logic [LANE_W-1:0] data_lane_a_in,
    input  wire logic [LANE_W-1:0] data_lane_b_in,
    input  wire logic [LANE_W-1:0] data_lane_c_in,
    input  wire logic [LANE_W-1:0] data_lane_d_in,
    output logic      [LANE_W-1:0] data_lane_a_out,
    output logic      [LANE_W-1:0] data_lane_b_out,
    output logic      [LANE_W-1:0] data_lane_c_out,
    output logic      [LANE_W-1:0] data_lane_d_out,
    output logic                   data_lane_a_oe_n,
    output logic                   data_lane_b_oe_n,
    output logic                   data_lane_c_oe_n,
    output logic                   data_lane_d_oe_n,
    // scan port held in its reset state, trace status
    output logic                   test_data_out,
    output logic                   test_data_oe_n,
    output logic                   trace_ready,
    // apb
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr
);
    typedef struct packed {
        logic                active;
        logic [UPPER_W-1:0]  upper;
        logic [1:0]          first;
        logic [1:0]          pos;
        logic                linear;
        logic [DATA_W-1:0]   q;
        logic                q_oe_n;
        logic                tap_reset;
        logic                tdo;
        logic                pready;
        logic [31:0]         prdata;
        logic                pslverr;
        logic                trace_en;
        logic [DROP_W-1:0]   drops;
        logic                trace_ready;
    } sbsc_state_s;

    sbsc_state_s           st_r;
    sbsc_state_s           st_nxt;
    logic [DATA_W-1:0]     mem_r [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0]     din;
    logic [LANES-1:0]      lane_wr_n;
    logic                  write_n;
    logic [LANES-1:0]      lane_en;
    logic                  wr_en;
    logic [ADDR_W-1:0]     acc_addr;

    // trace fifo handshake
    logic                  tr_valid;
    logic                  tr_ready;
    logic [TRACE_W-1:0]    tr_data;
    logic                  tr_out_valid;
    logic                  tr_pop;
    logic [TRACE_W-1:0]    tr_out_data;

    // low two address bits for a burst position
    function automatic logic [1:0] burst_low(input logic [1:0] first,
                                             input logic [1:0] pos,
                                             input logic       linear);
        burst_low = linear ? 2'(first + pos) : (first ^ pos); // RULE1 RULE2
    endfunction

    // full address of a burst position: only the low two bits move
    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [UPPER_W-1:0] upper,
        input logic [1:0]         first,
        input logic [1:0]         pos,
        input logic               linear);
        burst_addr = {upper, burst_low(first, pos, linear)}; // RULE19
    endfunction

    // one decoder for every register select, so the pop matches the read
    function automatic logic apb_hit(input logic [11:0] a,
                                     input logic [11:0] ofs);
        return a == ofs;
    endfunction

    // status word fields
    function automatic logic [31:0] status_word(input sbsc_state_s s,
                                                input logic        ready,
                                                input logic        pend);
        status_word = '0;
        status_word[STAT_ACTIVE_BIT] = s.active;
        status_word[STAT_POS_LSB +: 2] = s.pos;
        status_word[STAT_LINEAR_BIT] = s.linear;
        status_word[STAT_READY_BIT] = ready;
        status_word[STAT_PEND_BIT] = pend;
        status_word[STAT_TAPRST_BIT] = s.tap_reset;
        status_word[STAT_DROP_LSB +: DROP_W] = s.drops;
    endfunction

    assign din = {data_lane_d_in, data_lane_c_in,
                  data_lane_b_in, data_lane_a_in};
    assign lane_wr_n = {lane_d_write_n, lane_c_write_n,
                        lane_b_write_n, lane_a_write_n};
    // write: global write low, or gate low with any lane strobe low
    assign write_n = (byte_write_gate_n | (&lane_wr_n)) & global_write_n;

    // lane enables for a write cycle
    always_comb begin
        if (!global_write_n) begin
            lane_en = '1; // RULE12
        end else if (!byte_write_gate_n) begin
            lane_en = ~lane_wr_n; // RULE13
        end else begin
            lane_en = '0; // RULE12
        end
    end

    sbsc_fifo #(
        .WIDTH (TRACE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_trace_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_valid  (tr_valid),
        .in_ready  (tr_ready),
        .in_data   (tr_data),
        .out_valid (tr_out_valid),
        .out_ready (tr_pop),
        .out_data  (tr_out_data)
    );

    // pop only on the access edge of a trace read
    assign tr_pop = psel & penable & ~st_r.pready & ~pwrite
                    & apb_hit(paddr, OFS_TRACE);

    always_comb begin
        logic start_proc;
        logic start_ctrl;
        logic enabled;
        logic do_read;
        logic [1:0] npos;
        start_proc = 1'b0;
        start_ctrl = 1'b0;
        enabled    = 1'b0;
        do_read    = 1'b0;
        npos       = 2'b00;
        st_nxt     = st_r;
        wr_en      = 1'b0;
        acc_addr   = burst_addr(st_r.upper, st_r.first, st_r.pos,
                                st_r.linear);
        tr_valid   = 1'b0;
        tr_data    = '0;

        // processor strobe only counts under the primary enable
        start_proc = !addr_strobe_proc && !chip_enable_n; // RULE18
        start_ctrl = !addr_strobe_ctrl;
        enabled    = !chip_enable_n && depth_select && !depth_select_n;
        st_nxt.tap_reset = 1'b1; // RULE17

        if (start_proc || start_ctrl) begin
            if (enabled) begin
                st_nxt.active = 1'b1;
                st_nxt.upper  = addr[ADDR_W-1:2];
                st_nxt.first  = addr[1:0];
                st_nxt.pos    = 2'b00;
                st_nxt.linear = !burst_order_sel; // RULE1 RULE2
                acc_addr      = addr;
                if (start_proc) begin
                    do_read = 1'b1; // RULE3
                end else begin
                    wr_en   = !write_n; // RULE5
                    do_read = write_n; // RULE5
                end
                tr_valid = st_r.trace_en;
                tr_data  = {wr_en, addr};
            end else begin
                // the burst ends too, so later continue cycles idle
                st_nxt.active = 1'b0; // RULE6
            end
        end else if (st_r.active) begin
            // no strobe: continue or suspend
            npos = burst_step_n ? st_r.pos : 2'(st_r.pos + 1'b1); // RULE11
            st_nxt.pos = npos; // RULE19
            acc_addr = burst_addr(st_r.upper, st_r.first, npos,
                                  st_r.linear); // RULE19
            wr_en   = !write_n; // RULE8 RULE10 RULE4
            do_read = write_n; // RULE7 RULE9
        end

        // oe is sampled, not asynchronous: drive starts a cycle late
        if (do_read) begin
            st_nxt.q      = mem_r[acc_addr];
            st_nxt.q_oe_n = out_enable_n; // RULE7 RULE9
        end else begin
            st_nxt.q_oe_n = 1'b1; // RULE6 RULE8
        end

        // the block cannot stall a memory cycle, so full drops and counts
        if (tr_valid && !tr_ready && st_r.drops != '1) begin
            st_nxt.drops = st_r.drops + 1'b1;
        end
        st_nxt.trace_ready = tr_ready;

        // apb: one wait state, answer registered
        st_nxt.pready = psel && penable && !st_r.pready;
        if (psel && penable && !st_r.pready) begin
            st_nxt.prdata  = '0;
            st_nxt.pslverr = 1'b0;
            if (apb_hit(paddr, OFS_CTRL)) begin
                if (pwrite) begin
                    st_nxt.trace_en = pwdata[CTRL_TRACE_EN_BIT];
                end
                st_nxt.prdata[CTRL_TRACE_EN_BIT] = st_r.trace_en;
            end else if (apb_hit(paddr, OFS_STATUS)) begin
                st_nxt.prdata = status_word(st_r, tr_ready, tr_out_valid);
                if (pwrite) begin
                    // a drop in the clearing cycle still counts
                    st_nxt.drops = DROP_W'(tr_valid && !tr_ready);
                end
            end else if (apb_hit(paddr, OFS_TRACE)) begin
                if (!pwrite) begin
                    st_nxt.prdata[TRACE_VALID_BIT] = tr_out_valid;
                    // an empty fifo reads as zero, not a stale entry
                    if (tr_out_valid) begin
                        st_nxt.prdata[TRACE_W-1:0] = tr_out_data;
                    end
                end
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end
    end

    // storage kept out of the state struct: far too wide to pack
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_en && lane_en[i]) begin
                mem_r[acc_addr][i*LANE_W +: LANE_W] <=
                    din[i*LANE_W +: LANE_W]; // RULE13
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r          <= '0;
            st_r.q_oe_n   <= 1'b1; // RULE15
            st_r.tap_reset <= 1'b1; // RULE17
            st_r.trace_en <= CTRL_TRACE_EN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data_lane_a_out  = st_r.q[0*LANE_W +: LANE_W];
    assign data_lane_b_out  = st_r.q[1*LANE_W +: LANE_W];
    assign data_lane_c_out  = st_r.q[2*LANE_W +: LANE_W];
    assign data_lane_d_out  = st_r.q[3*LANE_W +: LANE_W];
    assign data_lane_a_oe_n = st_r.q_oe_n;
    assign data_lane_b_oe_n = st_r.q_oe_n;
    assign data_lane_c_oe_n = st_r.q_oe_n;
    assign data_lane_d_oe_n = st_r.q_oe_n;
    // scan logic sits in its reset state: output floats, memory untouched
    assign test_data_out    = st_r.tdo;
    assign test_data_oe_n   = st_r.tap_reset; // RULE17
    assign trace_ready      = st_r.trace_ready;
    assign pready           = st_r.pready;
    assign prdata           = st_r.prdata;
    assign pslverr          = st_r.pslverr;
endmodule // sbsc_top

/* tb/sbsc_ctrl_model.sv */
// memory controller model: drives the block's sram pins, resolves data wires
// assumes the bench calls cyc once per cycle from one thread
`timescale 1ns/1ps
module sbsc_ctrl_model
    import sbsc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic [DATA_W-1:0] dq_out,
    input  wire logic [LANES-1:0]  dq_oe_n,
    output logic      [DATA_W-1:0] dq_in,
    output logic      [ADDR_W-1:0] addr,
    output logic      [5:0]        strb,
    output logic      [5:0]        wr,
    output logic                   oe_n
);
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] last_r;
    logic [DATA_W-1:0] en_w;
    logic              drv_r;
    // no test clock pin: scan logic is never clocked
    initial begin
        addr = '0;
        strb = 6'h3e;
        wr = 6'h3f;
        oe_n = 1'b1;
        drv_r = 1'b0;
        wdata_r = '0;
        last_r = '0;
    end
    assign en_w = ~{{LANE_W{dq_oe_n[3]}}, {LANE_W{dq_oe_n[2]}},
                    {LANE_W{dq_oe_n[1]}}, {LANE_W{dq_oe_n[0]}}};
    // released wires toggle so a stale value can never pass for data
    assign dq_in = (dq_out & en_w) | (~en_w & (drv_r ? wdata_r : ~last_r));
    always @(posedge core_clk) last_r <= dq_in;
    // one cycle; the bench keeps oe high ahead of writes
    task automatic cyc(input logic [5:0] s, input logic [ADDR_W-1:0] a,
                       input logic [5:0] w, input logic [DATA_W-1:0] d,
                       input logic oe);
        @(posedge core_clk);
        strb <= s;
        addr <= a;
        wr <= w;
        wdata_r <= d;
        oe_n <= oe;
        drv_r <= !w[5] || (!w[4] && w[3:0] != 4'hf);
    endtask
endmodule // sbsc_ctrl_model

/* tb/sbsc_properties.sv */
// checker on the burst sram pins of sbsc_top, attached by bind
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/1ps
module sbsc_properties
    import sbsc_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire logic              chip_enable_n,
    input wire logic              depth_select,
    input wire logic              depth_select_n,
    input wire logic              addr_strobe_proc,
    input wire logic              addr_strobe_ctrl,
    input wire logic              burst_step_n,
    input wire logic              global_write_n,
    input wire logic              byte_write_gate_n,
    input wire logic              out_enable_n,
    input wire logic [LANE_W-1:0] data_lane_a_out,
    input wire logic              data_lane_a_oe_n,
    input wire logic              data_lane_b_oe_n,
    input wire logic              data_lane_c_oe_n,
    input wire logic              data_lane_d_oe_n,
    input wire logic              test_data_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // suspended read: no strobe, step held, no write condition
    wire rd_susp = addr_strobe_proc & addr_strobe_ctrl & burst_step_n
                   & global_write_n & byte_write_gate_n;
    deselect_floats_a: assert property (
        !addr_strobe_ctrl && chip_enable_n |=> data_lane_a_oe_n
        && data_lane_c_oe_n) else $error("deselect drove data");
    depth_off_a: assert property (
        !addr_strobe_proc && !chip_enable_n && !depth_select
        |=> data_lane_b_oe_n) else $error("depth deselect drove data");
    proc_read_a: assert property (
        !addr_strobe_proc && !chip_enable_n && depth_select
        && !depth_select_n && !out_enable_n
        |=> !data_lane_a_oe_n && !data_lane_d_oe_n) else $error("no read");
    oe_gate_a: assert property (
        out_enable_n |=> data_lane_b_oe_n) else $error("drove without oe");
    write_floats_a: assert property (
        addr_strobe_proc && !global_write_n |=> data_lane_a_oe_n)
        else $error("write cycle drove data");
    lanes_agree_a: assert property (
        {data_lane_b_oe_n, data_lane_c_oe_n, data_lane_d_oe_n}
        == {3{data_lane_a_oe_n}}) else $error("lane enables differ");
    suspend_hold_a: assert property (
        rd_susp ##1 rd_susp |=> data_lane_a_oe_n || $past(data_lane_a_oe_n)
        || $stable(data_lane_a_out)) else $error("suspend moved data");
    scan_idle_a: assert property (
        test_data_oe_n) else $error("scan output driven");
    powerup_float_a: assert property (
        $rose(rst_b) |-> data_lane_a_oe_n) else $error("driven at start");
endmodule // sbsc_properties

bind sbsc_top sbsc_properties props (.core_clk, .rst_b, .chip_enable_n,
    .depth_select, .depth_select_n, .addr_strobe_proc, .addr_strobe_ctrl,
    .burst_step_n, .global_write_n, .byte_write_gate_n, .out_enable_n,
    .data_lane_a_out, .data_lane_a_oe_n, .data_lane_b_oe_n, .data_lane_c_oe_n,
    .data_lane_d_oe_n, .test_data_oe_n);

/* tb/test_sync_burst_sram_cycle_control.sv */
// self-checking bench: sram pins through the model, registers through apb
// assumes model and checker compiled before this file
`timescale 1ns/1ps
module test_sync_burst_sram_cycle_control
    import sbsc_pkg::*;
;
    localparam logic [5:0]  PS = 6'h16, CS = 6'h26, BURST_STEP_N = 6'h3a;
    localparam logic [5:0]  SUS = 6'h3e, DES = 6'h2e, DDS = 6'h14;
    localparam logic [5:0]  PCH = 6'h1e, RD = 6'h3f, WALL = 6'h1f;
    localparam logic [5:0]  WB = 6'h2d, RG = 6'h30;
    localparam logic [16:0] B = 17'h0a5c4;
    logic              core_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              burst_order_sel = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0;
    logic [ADDR_W-1:0] addr;
    logic [5:0]        strb;
    logic [5:0]        wr;
    logic              out_enable_n;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic [LANES-1:0]  oe_n;
    logic [31:0]       prdata;
    logic [31:0]       r;
    logic              pready, pslverr, e;
    logic              trace_ready, test_data_out, test_data_oe_n;
    int                miscompares = 0;
    int                n_compared = 0;
    int                cycles = 0;
    always #2.5 core_clk = ~core_clk;
    sbsc_ctrl_model ctl (.core_clk, .dq_out, .dq_oe_n(oe_n), .dq_in, .addr,
        .strb, .wr, .oe_n(out_enable_n));
    sbsc_top dut (.core_clk, .rst_b, .addr, .burst_order_sel, .out_enable_n,
        .addr_strobe_proc(strb[5]), .addr_strobe_ctrl(strb[4]),
        .chip_enable_n(strb[3]), .burst_step_n(strb[2]),
        .depth_select(strb[1]), .depth_select_n(strb[0]),
        .global_write_n(wr[5]), .byte_write_gate_n(wr[4]),
        .lane_d_write_n(wr[3]), .lane_c_write_n(wr[2]),
        .lane_b_write_n(wr[1]), .lane_a_write_n(wr[0]),
        .data_lane_a_in(dq_in[8:0]), .data_lane_b_in(dq_in[17:9]),
        .data_lane_c_in(dq_in[26:18]), .data_lane_d_in(dq_in[35:27]),
        .data_lane_a_out(dq_out[8:0]), .data_lane_b_out(dq_out[17:9]),
        .data_lane_c_out(dq_out[26:18]), .data_lane_d_out(dq_out[35:27]),
        .data_lane_a_oe_n(oe_n[0]), .data_lane_b_oe_n(oe_n[1]),
        .data_lane_c_oe_n(oe_n[2]), .data_lane_d_oe_n(oe_n[3]),
        .test_data_out, .test_data_oe_n, .trace_ready, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
    function automatic logic [35:0] dv(input int i);
        return 36'h9a5c3e1b7 + 36'h111111111 * 36'(i);
    endfunction
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [35:0] x,
                       input logic [35:0] g);
        n_compared++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, x, g);
        end
    endtask
    // outputs of the cycle issued two calls ago, settled at mid-cycle
    task automatic ck(input logic [3:0] eo, input logic [35:0] ed);
        @(negedge core_clk);
        cmp("lane drive", 36'(eo), 36'(oe_n));
        if (eo == 4'h0)
            cmp("read data", ed, dq_out);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        ctl.cyc(SUS, '0, RD, '0, 1'b0);
        ctl.cyc(SUS, '0, RD, '0, 1'b1);
        ck(4'hf, '0);
        cmp("scan oe", 36'h1, 36'(test_data_oe_n));
        cmp("scan data", 36'h0, 36'(test_data_out));
        ctl.cyc(CS, B | 17'h1, WALL, dv(1), 1'b1);
        for (int i = 0; i < 3; i++)
            ctl.cyc(BURST_STEP_N, '0, WALL, dv(2 + i), 1'b1);
        ctl.cyc(SUS, '0, RD, '0, 1'b1);
        burst_order_sel <= 1'b0;
        ctl.cyc(PS, B | 17'h2, WALL, dv(9), 1'b0);
        ctl.cyc(BURST_STEP_N, '0, RD, '0, 1'b0);
        ck(4'h0, dv(4));
        ctl.cyc(SUS, '0, RD, '0, 1'b0);
        ck(4'h0, dv(3));
        ctl.cyc(SUS, '0, RD, '0, 1'b1);
        ck(4'h0, dv(3));
        ctl.cyc(BURST_STEP_N, '0, RD, '0, 1'b0);
        ck(4'hf, '0);
        ctl.cyc(BURST_STEP_N, '0, RD, '0, 1'b0);
        ck(4'h0, dv(2));
        ctl.cyc(SUS, '0, RD, '0, 1'b1);
        ck(4'h0, dv(1));
        ctl.cyc(PS, B | 17'h2, RD, '0, 1'b1);
        ctl.cyc(SUS, '0, WALL, dv(7), 1'b1);
        ctl.cyc(CS, B | 17'h2, RD, '0, 1'b0);
        ctl.cyc(SUS, '0, RD, '0, 1'b1);
        ck(4'h0, dv(7));
        ctl.cyc(CS, B | 17'h2, WB, dv(8), 1'b1);
        ctl.cyc(CS, B | 17'h2, RG, dv(5), 1'b0);
        ck(4'hf, '0);
        ctl.cyc(SUS, '0, RD, '0, 1'b1);
        ck(4'h0, (dv(7) & 36'hffffc01ff)
                 | (dv(8) & 36'h00003fe00));
        ctl.cyc(DES, B, WALL, dv(6), 1'b0);
        ctl.cyc(BURST_STEP_N, '0, RD, '0, 1'b0);
        ck(4'hf, '0);
        ctl.cyc(DDS, B, RD, '0, 1'b0);
        ck(4'hf, '0);
        ctl.cyc(CS, B, RD, '0, 1'b1);
        ck(4'hf, '0);
        ctl.cyc(PCH, B, RD, '0, 1'b0);
        ctl.cyc(SUS, '0, RD, '0, 1'b0);
        ck(4'h0, dv(2));
        apb(1'b0, OFS_CTRL, 32'h0);
        cmp("ctrl reset", 36'(CTRL_TRACE_EN_RST), 36'(r));
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        cmp("unmapped error", 36'h1, 36'(e));
        for (int i = 0; i < 10; i++)
            ctl.cyc(CS, B + 17'(i), RD, '0, 1'b1);
        ctl.cyc(SUS, '0, RD, '0, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp("drop count", 36'h2, 36'(r[23:16]));
        cmp("fifo ready", 36'h0, 36'(trace_ready));
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, OFS_TRACE, 32'h0);
            cmp("trace word", (i < 8) ? 36'h80000000 + 36'(B + 17'(i)) : 0,
                36'(r));
        end
        cmp("fifo ready", 36'h1, 36'(trace_ready));
        test_done();
    end
endmodule // test_sync_burst_sram_cycle_control
